/* File: dv/slrr_host_model.sv */
// host-side register bus driver for the ringing/ram control bank
`timescale 1ns/100ps
`default_nettype none
module slrr_host_model (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata_q,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic reg_chan,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // bus idle from time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_chan = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one write strobe, held for exactly one taking edge
  task automatic wr(input logic ch, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_chan <= ch;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  // one read strobe; data is taken once the taking edge has landed
  task automatic rd(input logic ch, input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_chan <= ch;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask : rd
endmodule : slrr_host_model
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the ringing/ram control bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {logic ch; logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} slrr_row_t;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic mem_update_tick = 1'b0;
  logic [1:0] ring_request = 2'h0;
  logic [1:0] wave = 2'h0;
  logic [1:0] conv = 2'h0;
  logic reg_wr_en, reg_rd_en, reg_chan, pll_reinit_q, busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic [1:0] ring_osc_en, unb_en, unb_rev, trap;
  int mismatches = 0;
  int n_compared = 0;
  int pll_seen = 0;
  slrr_row_t rows [0:12];
  logic [7:0] regs [0:9] = '{8'h01, 8'h04, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h65, 8'h66, 8'h67};

  slrr_host_model i_slrr_host_model (.core_clk(core_clk), .reg_rdata_q(reg_rdata_q), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  slrr_regs i_slrr_regs (.core_clk(core_clk), .rstn(rstn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .mem_update_tick(mem_update_tick), .ring_request(ring_request), .ring_wave_present(wave),
    .ring_to_diff_converter(conv), .ring_osc_en(ring_osc_en), .unbalanced_ring_enable(unb_en),
    .unbalanced_reverse_select(unb_rev), .ring_trapezoid(trap), .pll_reinit_q(pll_reinit_q),
    .indirect_busy_flag(busy));

  // 100 mhz clock
  always #5 core_clk = ~core_clk;

  // counts full-reset pulses
  always @(posedge core_clk) begin
    if (pll_reinit_q === 1'b1) begin
      pll_seen++;
    end
  end

  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  function automatic logic flag(input int k);
    return k == 0 ? busy : ring_osc_en[0];
  endfunction : flag

  // bounded wait for busy (k=0) or channel a oscillator (k=1) to reach a level
  task automatic wait_flag(input int k, input logic v, input int lim);
    int i;
    i = 0;
    while (flag(k) !== v && i < lim) begin
      @(negedge core_clk);
      i++;
    end
    if (flag(k) !== v) begin
      $display("ERROR wait flag %0d expected %b seen %b", k, v, flag(k));
      mismatches++;
      stop_test();
    end
  endtask : wait_flag

  task automatic rdc(input logic ch, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_slrr_host_model.rd(ch, a, d);
    check($sformatf("reg %h ch %b", a, ch), {8'h00, d}, {8'h00, e});
  endtask : rdc

  // launch at a location, peek the low data byte before the update cycle, then wait for idle
  task automatic ram_op(input logic [7:0] loc, input logic [7:0] pre);
    i_slrr_host_model.wr(1'b0, 8'h67, loc);
    #1;
    check("busy launched", {15'h0000, busy}, 16'h0001);
    rdc(1'b0, 8'h65, pre);
    rdc(1'b0, 8'h04, 8'h01);
    @(posedge core_clk);
    mem_update_tick <= 1'b1;
    @(posedge core_clk);
    mem_update_tick <= 1'b0;
    wait_flag(0, 1'b0, 20);
  endtask : ram_op

  // measures how long channel a oscillator stays at a level
  task automatic count_osc(input logic v, output int n);
    n = 0;
    while (ring_osc_en[0] === v && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
  endtask : count_osc

  initial begin
    int n;
    rows = '{{1'b0, 8'h17, 1'b1, 8'hff, 8'h3b}, {1'b1, 8'h17, 1'b1, 8'h21, 8'h21}, {1'b0, 8'h17, 1'b0, 8'h00, 8'h3b},
      {1'b0, 8'h18, 1'b1, 8'ha5, 8'ha5}, {1'b1, 8'h19, 1'b1, 8'h5a, 8'h5a}, {1'b1, 8'h18, 1'b0, 8'h00, 8'h00},
      {1'b1, 8'h1a, 1'b1, 8'h3c, 8'h3c}, {1'b1, 8'h1b, 1'b1, 8'hc3, 8'hc3}, {1'b0, 8'h65, 1'b1, 8'h12, 8'h12},
      {1'b1, 8'h65, 1'b0, 8'h00, 8'h12}, {1'b1, 8'h66, 1'b1, 8'h34, 8'h34}, {1'b1, 8'h04, 1'b1, 8'hff, 8'h00},
      {1'b0, 8'h02, 1'b1, 8'hff, 8'h00}};
    repeat (8) @(posedge core_clk);
    check("busy in reset", {15'h0000, busy}, 16'h0001);
    rstn <= 1'b1;
    wait_flag(0, 1'b0, 300);
    for (int i = 0; i < 20; i++) begin
      rdc(i[0], regs[i / 2], 8'h00);
    end
    $display("test reset values done");
    // table rows: optional write, then read back
    foreach (rows[i]) begin
      if (rows[i].w) begin
        i_slrr_host_model.wr(rows[i].ch, rows[i].a, rows[i].d);
      end
      rdc(rows[i].ch, rows[i].a, rows[i].e);
    end
    check("cfg outputs", {10'h000, unb_en, unb_rev, trap}, {10'h000, 2'b11, 2'b01, 2'b11});
    @(posedge core_clk);
    wave <= 2'b01;
    conv <= 2'b10;
    rdc(1'b0, 8'h17, 8'hbb);
    rdc(1'b1, 8'h17, 8'h61);
    @(posedge core_clk);
    wave <= 2'b00;
    conv <= 2'b00;
    $display("test register table done");
    ram_op(8'h10, 8'h12);
    ram_op(8'h20, 8'h12);
    rdc(1'b0, 8'h65, 8'h00);
    rdc(1'b0, 8'h66, 8'h00);
    ram_op(8'h10, 8'h00);
    rdc(1'b0, 8'h65, 8'h12);
    rdc(1'b0, 8'h66, 8'h34);
    $display("test indirect ram done");
    i_slrr_host_model.wr(1'b0, 8'h01, 8'h02);
    repeat (3) @(posedge core_clk);
    rdc(1'b1, 8'h17, 8'h00);
    rdc(1'b1, 8'h1a, 8'h00);
    rdc(1'b0, 8'h17, 8'h3b);
    rdc(1'b0, 8'h18, 8'ha5);
    rdc(1'b0, 8'h01, 8'h00);
    rdc(1'b0, 8'h65, 8'h12);
    check("pll pulses", 16'(pll_seen), 16'h0000);
    $display("test channel reset done");
    i_slrr_host_model.wr(1'b0, 8'h01, 8'h03);
    repeat (3) @(posedge core_clk);
    #1;
    check("pll pulses", 16'(pll_seen), 16'h0001);
    check("busy sweep", {15'h0000, busy}, 16'h0001);
    wait_flag(0, 1'b0, 300);
    rdc(1'b0, 8'h65, 8'h00);
    rdc(1'b0, 8'h18, 8'h00);
    rdc(1'b0, 8'h17, 8'h00);
    i_slrr_host_model.wr(1'b0, 8'h65, 8'hff);
    ram_op(8'h30, 8'hff);
    ram_op(8'h10, 8'hff);
    rdc(1'b0, 8'h65, 8'h00);
    $display("test full reset done");
    @(posedge core_clk);
    ring_request <= 2'b01;
    wait_flag(1, 1'b1, 10);
    rdc(1'b0, 8'h17, 8'h04);
    @(posedge core_clk);
    ring_request <= 2'b00;
    wait_flag(1, 1'b0, 10);
    rdc(1'b0, 8'h17, 8'h00);
    i_slrr_host_model.wr(1'b0, 8'h18, 8'h02);
    i_slrr_host_model.wr(1'b0, 8'h1a, 8'h01);
    i_slrr_host_model.wr(1'b0, 8'h17, 8'h18);
    @(posedge core_clk);
    ring_request <= 2'b01;
    wait_flag(1, 1'b1, 10);
    count_osc(1'b1, n);
    check("on cycles", 16'(n), 16'h00fa);
    count_osc(1'b0, n);
    check("off cycles", 16'(n), 16'h007d);
    check("osc again", {15'h0000, ring_osc_en[0]}, 16'h0001);
    @(posedge core_clk);
    ring_request <= 2'b00;
    wait_flag(1, 1'b0, 10);
    // on-timer only: one burst, then the oscillator holds off while still requested
    i_slrr_host_model.wr(1'b0, 8'h17, 8'h10);
    @(posedge core_clk);
    ring_request <= 2'b01;
    wait_flag(1, 1'b1, 10);
    count_osc(1'b1, n);
    check("hold on cycles", 16'(n), 16'h00fa);
    repeat (300) @(negedge core_clk);
    check("hold off", {15'h0000, ring_osc_en[0]}, 16'h0000);
    @(posedge core_clk);
    ring_request <= 2'b00;
    $display("test cadence done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

/* File: hw/slrr_cadence.sv */
// per-channel ringing cadence sequencer: on-time / off-time burst timing
`timescale 1ns/100ps
`default_nettype none
`include "slrr_params.svh"
module slrr_cadence (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic chan_rst,
  input wire logic ring_request,
  input wire logic on_time_timer_enable,
  input wire logic off_time_timer_enable,
  input wire logic [15:0] burst_on_time,
  input wire logic [15:0] burst_off_time,
  output logic osc_running_q
);
  slrr_pkg::slrr_cad_state_t state_q;
  slrr_pkg::slrr_cad_state_t state_d;
  logic [6:0] pre_q;
  logic [15:0] count_q;
  logic tick;
  logic expire;
  logic [15:0] period;

  // 1.25 us time base, free-running in every state, restarted at each phase change and channel reset
  assign tick = (pre_q == 7'(`SLRR_LSB_CYCLES - 1));
  assign period = (state_q == slrr_pkg::SLRR_CAD_ON) ? burst_on_time : burst_off_time;
  assign expire = (period == 16'h0000) || (tick && (count_q == period - 16'h0001));

  // next state of the burst sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      slrr_pkg::SLRR_CAD_IDLE: begin
        if (ring_request) state_d = slrr_pkg::SLRR_CAD_ON;
      end
      slrr_pkg::SLRR_CAD_ON: begin
        if (!ring_request) state_d = slrr_pkg::SLRR_CAD_IDLE;
        else if (on_time_timer_enable && expire) begin
          state_d = off_time_timer_enable ? slrr_pkg::SLRR_CAD_OFF : slrr_pkg::SLRR_CAD_HOLD;
        end
      end
      slrr_pkg::SLRR_CAD_OFF: begin
        if (!ring_request) state_d = slrr_pkg::SLRR_CAD_IDLE;
        else if (expire) state_d = slrr_pkg::SLRR_CAD_ON;
      end
      slrr_pkg::SLRR_CAD_HOLD: begin
        if (!ring_request) state_d = slrr_pkg::SLRR_CAD_IDLE;
      end
      default: state_d = slrr_pkg::SLRR_CAD_IDLE;
    endcase
  end

  // state and oscillator enable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= slrr_pkg::SLRR_CAD_IDLE;
      osc_running_q <= 1'b0;
    end else if (chan_rst) begin
      state_q <= slrr_pkg::SLRR_CAD_IDLE;
      osc_running_q <= 1'b0;
    end else begin
      state_q <= state_d;
      osc_running_q <= (state_d == slrr_pkg::SLRR_CAD_ON);
    end
  end

  // prescaler and lsb counter restart at every phase change
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 7'h00;
      count_q <= 16'h0000;
    end else if (chan_rst || (state_d != state_q)) begin
      pre_q <= 7'h00;
      count_q <= 16'h0000;
    end else begin
      pre_q <= tick ? 7'h00 : pre_q + 7'h01;
      if (tick) count_q <= count_q + 16'h0001;
    end
  end

  a_osc_follows_state: assert property (@(posedge core_clk) disable iff (!rstn)
    osc_running_q == (state_q == slrr_pkg::SLRR_CAD_ON)) else $error("oscillator enable disagrees with state");
  a_gap_then_burst: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_q == slrr_pkg::SLRR_CAD_OFF && ring_request && expire && !chan_rst) |=> osc_running_q)
    else $error("burst did not resume after gap");
  c_gap_entered: cover property (@(posedge core_clk) disable iff (!rstn)
    state_q == slrr_pkg::SLRR_CAD_ON ##1 state_q == slrr_pkg::SLRR_CAD_OFF);
endmodule : slrr_cadence
`default_nettype wire

/* File: hw/slrr_params.svh */
// register offsets, field positions, reset values and timing counts of the ringing/ram control bank
`ifndef SLRR_PARAMS_SVH
`define SLRR_PARAMS_SVH

`define SLRR_ADDR_SOFT_RESET 8'h01
`define SLRR_ADDR_RAM_STATUS 8'h04
`define SLRR_ADDR_RING_CONFIG 8'h17
`define SLRR_ADDR_ON_TIME_LO 8'h18
`define SLRR_ADDR_ON_TIME_HI 8'h19
`define SLRR_ADDR_OFF_TIME_LO 8'h1a
`define SLRR_ADDR_OFF_TIME_HI 8'h1b
`define SLRR_ADDR_DATA_LO 8'h65
`define SLRR_ADDR_DATA_HI 8'h66
`define SLRR_ADDR_LOC_SELECT 8'h67

`define SLRR_BIT_WAVE_PRESENT 7
`define SLRR_BIT_TO_DIFF_CONV 6
`define SLRR_BIT_UNBAL_ENABLE 5
`define SLRR_BIT_ON_TIMER_EN 4
`define SLRR_BIT_OFF_TIMER_EN 3
`define SLRR_BIT_OSC_MONITOR 2
`define SLRR_BIT_UNBAL_REVERSE 1
`define SLRR_BIT_TRAPEZOID 0
`define SLRR_CFG_WRITE_MASK 8'h3b

`define SLRR_RST_SOFT_RESET 2'h0
`define SLRR_RST_RING_CONFIG 8'h00
`define SLRR_RST_TIME 16'h0000
`define SLRR_RST_DATA 16'h0000
`define SLRR_RST_LOC_SELECT 8'h00

`define SLRR_RAM_DEPTH 256
`define SLRR_LSB_TIME_NS 1250
`define SLRR_CLK_PERIOD_NS 10
`define SLRR_LSB_CYCLES (`SLRR_LSB_TIME_NS / `SLRR_CLK_PERIOD_NS)

`endif

/* File: hw/slrr_pkg.sv */
// types shared by the ringing/ram control bank
package slrr_pkg;
  typedef enum logic [1:0] {
    SLRR_CAD_IDLE = 2'b00,
    SLRR_CAD_ON = 2'b01,
    SLRR_CAD_OFF = 2'b10,
    SLRR_CAD_HOLD = 2'b11
  } slrr_cad_state_t;
endpackage : slrr_pkg

/* File: hw/slrr_regs.sv */
// dual-channel ringing configuration, soft reset and indirect ram register bank
`timescale 1ns/100ps
`default_nettype none
`include "slrr_params.svh"
module slrr_regs (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic reg_chan,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic mem_update_tick,
  input wire logic [1:0] ring_request,
  input wire logic [1:0] ring_wave_present,
  input wire logic [1:0] ring_to_diff_converter,
  output logic [1:0] ring_osc_en,
  output logic [1:0] unbalanced_ring_enable,
  output logic [1:0] unbalanced_reverse_select,
  output logic [1:0] ring_trapezoid,
  output logic pll_reinit_q,
  output logic indirect_busy_flag
);
  logic [1:0] soft_reset_q;
  logic full_reset;
  logic [1:0] chan_rst;
  logic [15:0] indirect_data_value_q;
  logic [7:0] indirect_location_select_q;
  logic pending_q;
  logic op_write_q;
  logic data_dirty_q;
  logic clearing_q;
  logic [7:0] clr_idx_q;
  logic [15:0] ram_mem [`SLRR_RAM_DEPTH];
  logic [15:0] ram_rd_word;
  logic update_go;
  logic [1:0][7:0] cfg_all;
  logic [1:0][15:0] on_all;
  logic [1:0][15:0] off_all;
  logic [1:0] osc_all;
  logic [7:0] cfg_view;
  logic [7:0] rd_d;
  logic wr_soft;
  logic wr_lo;
  logic wr_hi;
  logic wr_loc;

  // shared register write strobes
  assign wr_soft = reg_wr_en && (reg_addr == `SLRR_ADDR_SOFT_RESET);
  assign wr_lo = reg_wr_en && (reg_addr == `SLRR_ADDR_DATA_LO);
  assign wr_hi = reg_wr_en && (reg_addr == `SLRR_ADDR_DATA_HI);
  assign wr_loc = reg_wr_en && (reg_addr == `SLRR_ADDR_LOC_SELECT);

  // soft reset request is held one cycle, then acted on and cleared
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      soft_reset_q <= `SLRR_RST_SOFT_RESET;
    end else if (soft_reset_q != 2'b00) begin
      soft_reset_q <= `SLRR_RST_SOFT_RESET;
    end else if (wr_soft) begin
      soft_reset_q <= reg_wdata[1:0];
    end
  end

  // a single bit restarts one channel; both bits restart the whole device
  assign full_reset = (soft_reset_q == 2'b11);
  assign chan_rst = soft_reset_q;

  // clock-synthesis loop restart pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pll_reinit_q <= 1'b0;
    end else begin
      pll_reinit_q <= full_reset;
    end
  end

  // ram clear sweep, run after power-up and after a full soft reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clearing_q <= 1'b1;
      clr_idx_q <= 8'h00;
    end else if (full_reset) begin
      clearing_q <= 1'b1;
      clr_idx_q <= 8'h00;
    end else if (clearing_q) begin
      clr_idx_q <= clr_idx_q + 8'h01;
      if (clr_idx_q == 8'hff) clearing_q <= 1'b0;
    end
  end

  // an indirect access completes on the next update cycle once no sweep runs
  assign update_go = mem_update_tick && pending_q && !clearing_q;
  assign ram_rd_word = ram_mem[indirect_location_select_q];

  // coefficient ram storage
  always_ff @(posedge core_clk) begin
    if (clearing_q) begin
      ram_mem[clr_idx_q] <= 16'h0000;
    end else if (update_go && op_write_q) begin
      ram_mem[indirect_location_select_q] <= indirect_data_value_q;
    end
  end

  // address register; a write to it launches the access
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      indirect_location_select_q <= `SLRR_RST_LOC_SELECT;
    end else if (full_reset) begin
      indirect_location_select_q <= `SLRR_RST_LOC_SELECT;
    end else if (wr_loc) begin
      indirect_location_select_q <= reg_wdata;
    end
  end

  // pending access and its direction; a new launch wins over completion
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pending_q <= 1'b0;
      op_write_q <= 1'b0;
      data_dirty_q <= 1'b0;
    end else if (full_reset) begin
      pending_q <= 1'b0;
      op_write_q <= 1'b0;
      data_dirty_q <= 1'b0;
    end else begin
      if (wr_loc) begin
        pending_q <= 1'b1;
        op_write_q <= data_dirty_q;
      end else if (update_go) begin
        pending_q <= 1'b0;
      end
      if (wr_lo || wr_hi) data_dirty_q <= 1'b1;
      else if (wr_loc) data_dirty_q <= 1'b0;
    end
  end

  // data word: host bytes, or the ram word fetched by a read access
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      indirect_data_value_q <= `SLRR_RST_DATA;
    end else if (full_reset) begin
      indirect_data_value_q <= `SLRR_RST_DATA;
    end else if (wr_lo) begin
      indirect_data_value_q[7:0] <= reg_wdata;
    end else if (wr_hi) begin
      indirect_data_value_q[15:8] <= reg_wdata;
    end else if (update_go && !op_write_q) begin
      indirect_data_value_q <= ram_rd_word;
    end
  end

  assign indirect_busy_flag = pending_q || clearing_q;

  // per-channel ringing configuration, timers and cadence sequencer
  for (genvar ch = 0; ch < 2; ch++) begin : chan_g
    logic [7:0] cfg_q;
    logic [15:0] on_q;
    logic [15:0] off_q;
    logic sel;
    assign sel = reg_wr_en && (reg_chan == 1'(ch));

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        cfg_q <= `SLRR_RST_RING_CONFIG;
        on_q <= `SLRR_RST_TIME;
        off_q <= `SLRR_RST_TIME;
      end else if (chan_rst[ch]) begin
        cfg_q <= `SLRR_RST_RING_CONFIG;
        on_q <= `SLRR_RST_TIME;
        off_q <= `SLRR_RST_TIME;
      end else if (sel) begin
        case (reg_addr)
          `SLRR_ADDR_RING_CONFIG: cfg_q <= reg_wdata & `SLRR_CFG_WRITE_MASK;
          `SLRR_ADDR_ON_TIME_LO: on_q[7:0] <= reg_wdata;
          `SLRR_ADDR_ON_TIME_HI: on_q[15:8] <= reg_wdata;
          `SLRR_ADDR_OFF_TIME_LO: off_q[7:0] <= reg_wdata;
          `SLRR_ADDR_OFF_TIME_HI: off_q[15:8] <= reg_wdata;
          default: cfg_q <= cfg_q;
        endcase
      end
    end

    slrr_cadence u_cadence (
      .core_clk(core_clk),
      .rstn(rstn),
      .chan_rst(chan_rst[ch]),
      .ring_request(ring_request[ch]),
      .on_time_timer_enable(cfg_q[`SLRR_BIT_ON_TIMER_EN]),
      .off_time_timer_enable(cfg_q[`SLRR_BIT_OFF_TIMER_EN]),
      .burst_on_time(on_q),
      .burst_off_time(off_q),
      .osc_running_q(osc_all[ch])
    );

    assign cfg_all[ch] = cfg_q;
    assign on_all[ch] = on_q;
    assign off_all[ch] = off_q;
    assign unbalanced_ring_enable[ch] = cfg_q[`SLRR_BIT_UNBAL_ENABLE];
    assign unbalanced_reverse_select[ch] = cfg_q[`SLRR_BIT_UNBAL_REVERSE];
    assign ring_trapezoid[ch] = cfg_q[`SLRR_BIT_TRAPEZOID];
    assign ring_osc_en[ch] = osc_all[ch];
  end

  // configuration view with the live monitor bits merged in
  always_comb begin
    cfg_view = cfg_all[reg_chan];
    cfg_view[`SLRR_BIT_WAVE_PRESENT] = ring_wave_present[reg_chan];
    cfg_view[`SLRR_BIT_TO_DIFF_CONV] = ring_to_diff_converter[reg_chan];
    cfg_view[`SLRR_BIT_OSC_MONITOR] = osc_all[reg_chan];
  end

  // read multiplexer; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      `SLRR_ADDR_SOFT_RESET: rd_d = {6'h00, soft_reset_q};
      `SLRR_ADDR_RAM_STATUS: rd_d = {7'h00, indirect_busy_flag};
      `SLRR_ADDR_RING_CONFIG: rd_d = cfg_view;
      `SLRR_ADDR_ON_TIME_LO: rd_d = on_all[reg_chan][7:0];
      `SLRR_ADDR_ON_TIME_HI: rd_d = on_all[reg_chan][15:8];
      `SLRR_ADDR_OFF_TIME_LO: rd_d = off_all[reg_chan][7:0];
      `SLRR_ADDR_OFF_TIME_HI: rd_d = off_all[reg_chan][15:8];
      `SLRR_ADDR_DATA_LO: rd_d = indirect_data_value_q[7:0];
      `SLRR_ADDR_DATA_HI: rd_d = indirect_data_value_q[15:8];
      `SLRR_ADDR_LOC_SELECT: rd_d = indirect_location_select_q;
      default: rd_d = 8'h00;
    endcase
  end

  // read data register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata_q <= rd_d;
    end
  end

  // checks on the register behaviour
  a_busy_after_addr: assert property (@(posedge core_clk) disable iff (!rstn)
    (wr_loc && !full_reset) |=> indirect_busy_flag) else $error("address write did not raise busy");

  a_write_lands: assert property (@(posedge core_clk) disable iff (!rstn)
    (update_go && op_write_q) |=> ram_mem[$past(indirect_location_select_q)] == $past(indirect_data_value_q))
    else $error("ram word not stored");

  a_read_loads: assert property (@(posedge core_clk) disable iff (!rstn)
    (update_go && !op_write_q && !wr_lo && !wr_hi && !full_reset)
    |=> indirect_data_value_q == $past(ram_rd_word)) else $error("ram word not fetched");

  a_no_early_read: assert property (@(posedge core_clk) disable iff (!rstn)
    (pending_q && !mem_update_tick && !wr_lo && !wr_hi && !full_reset)
    |=> $stable(indirect_data_value_q)) else $error("data changed before update cycle");

  a_status_format: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_rd_en && reg_addr == `SLRR_ADDR_RAM_STATUS)
    |=> reg_rdata_q == {7'h00, $past(indirect_busy_flag)}) else $error("status read wrong");

  a_soft_single: assert property (@(posedge core_clk) disable iff (!rstn)
    (soft_reset_q == 2'b10 && !reg_wr_en)
    |=> cfg_all[1] == 8'h00 && on_all[1] == 16'h0000 && off_all[1] == 16'h0000 && $stable(cfg_all[0])
    && $stable(on_all[0])) else $error("single channel reset wrong");

  a_soft_self_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    (soft_reset_q != 2'b00) |=> soft_reset_q == 2'b00) else $error("soft reset did not clear");

  a_full_sweep: assert property (@(posedge core_clk) disable iff (!rstn)
    (full_reset) |=> pll_reinit_q && clearing_q ##256 !clearing_q) else $error("full reset sequence wrong");

  a_cfg_readback: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_rd_en && reg_addr == `SLRR_ADDR_RING_CONFIG) |=> reg_rdata_q == $past(cfg_view)
    && reg_rdata_q[`SLRR_BIT_OSC_MONITOR] == $past(ring_osc_en[reg_chan])) else $error("config read wrong");

  a_cfg_drives: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_wr_en && reg_chan == 1'b0 && reg_addr == `SLRR_ADDR_RING_CONFIG && soft_reset_q == 2'b00)
    |=> unbalanced_ring_enable[0] == $past(reg_wdata[5]) && unbalanced_reverse_select[0] == $past(reg_wdata[1])
    && ring_trapezoid[0] == $past(reg_wdata[0])) else $error("config bits not applied");

  a_on_time_bytes: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_wr_en && reg_chan == 1'b1 && reg_addr == `SLRR_ADDR_ON_TIME_HI && soft_reset_q == 2'b00)
    |=> on_all[1][15:8] == $past(reg_wdata)) else $error("on-time high byte not stored");

  a_shared_survive: assert property (@(posedge core_clk) disable iff (!rstn)
    (soft_reset_q == 2'b10 && !reg_wr_en && !update_go)
    |=> $stable(indirect_data_value_q) && $stable(indirect_location_select_q) && !pll_reinit_q)
    else $error("single channel reset touched shared state");

  a_data_hi_byte: assert property (@(posedge core_clk) disable iff (!rstn)
    (wr_hi && !full_reset) |=> indirect_data_value_q[15:8] == $past(reg_wdata))
    else $error("data high byte not stored");

  a_low_byte_only: assert property (@(posedge core_clk) disable iff (!rstn)
    (wr_lo && !full_reset) |=> indirect_data_value_q == {$past(indirect_data_value_q[15:8]), $past(reg_wdata)})
    else $error("data low byte not stored alone");

  a_loc_readback: assert property (@(posedge core_clk) disable iff (!rstn)
    (wr_loc && !full_reset) |=> indirect_location_select_q == $past(reg_wdata))
    else $error("location select not stored");

  a_off_time_bytes: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_wr_en && reg_chan == 1'b1 && reg_addr == `SLRR_ADDR_OFF_TIME_LO && soft_reset_q == 2'b00)
    |=> off_all[1][7:0] == $past(reg_wdata)) else $error("off-time low byte not stored");

  a_busy_clears: assert property (@(posedge core_clk) disable iff (!rstn)
    (update_go && !wr_loc && !full_reset) |=> !indirect_busy_flag) else $error("busy stayed after completion");

  a_soft_reads_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_rd_en && reg_addr == `SLRR_ADDR_SOFT_RESET) |=> reg_rdata_q[7:2] == 6'h00)
    else $error("soft reset upper bits not zero");

  a_pll_one_shot: assert property (@(posedge core_clk) disable iff (!rstn)
    pll_reinit_q |=> !pll_reinit_q) else $error("clock loop restart longer than one cycle");

  c_ram_write: cover property (@(posedge core_clk) disable iff (!rstn) update_go && op_write_q);
  c_ram_read: cover property (@(posedge core_clk) disable iff (!rstn) update_go && !op_write_q);
  c_full_reset: cover property (@(posedge core_clk) disable iff (!rstn) full_reset);
  c_single_reset: cover property (@(posedge core_clk) disable iff (!rstn) soft_reset_q == 2'b10);
endmodule : slrr_regs
`default_nettype wire
